// [rtl/focd_coder.sv]
// flash converter output coder: constants package and the coder module
// assumes a single core clock; converter pins and strobes arrive synchronous to it
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ns

//------------------------------------------------------------
// constants
//------------------------------------------------------------
package focd_pkg;
	localparam int       ADDR_W        = 8;
	localparam int       BUS_W         = 32;
	localparam int       DATA_W_DOC    = 8;
	localparam [7:0]     OFF_CTRL      = 8'h00;
	localparam [7:0]     OFF_STATUS    = 8'h04;
	localparam [7:0]     OFF_MASK      = 8'h08;
	localparam [7:0]     OFF_SAMPLE    = 8'h0C;
	localparam int       MODE_W        = 2;
	localparam [1:0]     MODE_TTL_TRUE = 2'h0;
	localparam [1:0]     MODE_TTL_COMP = 2'h1;
	localparam [1:0]     MODE_AC_TRUE  = 2'h2;
	localparam [1:0]     MODE_AC_COMP  = 2'h3;
	localparam [1:0]     CTRL_RESET    = 2'h0;
	localparam int       EVT_W         = 3;
	localparam int       ST_SAMPLE     = 0;
	localparam int       ST_UNDER      = 1;
	localparam int       ST_OVER       = 2;
	localparam [2:0]     STATUS_RESET  = 3'h0;
	localparam [2:0]     MASK_RESET    = 3'h0;
	localparam int       SAMPLE_FLAG   = 8;
	localparam [0:0]     TC_TWOS       = 1'h0;
endpackage

//------------------------------------------------------------
// coder
//------------------------------------------------------------
// Operation
// R1: in the first single-ended mode a sample is taken on each rising edge of the true clock.
// R2: in the second single-ended mode a sample is taken on each falling edge of the complementary clock.
// R3: with the true clock driven by a small ac signal, sampling is on its rising transition.
// R4: with the complementary clock driven by such a signal, sampling is on its falling transition.
// R5: below the zero-code level the range flag is set and the code is all zeros, or 10000000 in two's complement.
// R6: above full scale the range flag is set and the code is all ones, or 01111111 in two's complement.
// R7: in range the flag is low and the binary word equals the step number 0 to 255, bit 7 most significant.
// R8: the two's-complement word is the binary word with its top bit inverted.
// R9: the sample word goes out on eight parallel data lines that can be floated.
// R10: while the active-low chip enable is high, data lines and range flag are floated whatever the format select.
// R11: with chip enable low the outputs are driven; format select low picks two's complement, high binary.
// R12: data word and range flag are updated together once per selected sampling edge.
module focd_coder #(
	parameter int DATA_W = focd_pkg::DATA_W_DOC
) (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_ce,
	input  wire logic                        i_true_clock,
	input  wire logic                        i_complementary_clock,
	input  wire logic [DATA_W-1:0]           i_conv_code,
	input  wire logic                        i_below_zero,
	input  wire logic                        i_above_full,
	input  wire logic                        i_chip_enable_n,
	input  wire logic                        i_twos_complement_select_n,
	input  wire logic [focd_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [focd_pkg::BUS_W-1:0]  i_wr_data,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [focd_pkg::BUS_W-1:0]  o_rd_data,
	output logic      [DATA_W-1:0]           o_sample_word,
	output logic                             o_sample_word_oe,
	output logic                             o_range_flag,
	output logic                             o_range_flag_oe,
	output logic                             o_irq
);

	generate
		if (DATA_W < 2 || DATA_W > focd_pkg::SAMPLE_FLAG) begin : g_bad_width
			$error("sample width must lie between 2 and 8");
		end
	endgenerate

	//------------------------------------------------------------
	// functions
	//------------------------------------------------------------
	// true-side modes take rising true edges, the others falling complementary edges
	function automatic logic edge_for_mode(
		input logic [focd_pkg::MODE_W-1:0] mode,
		input logic                        rise_true,
		input logic                        fall_comp
	);
		logic hit;
		hit = fall_comp;
		if (mode == focd_pkg::MODE_TTL_TRUE || mode == focd_pkg::MODE_AC_TRUE) begin
			hit = rise_true;
		end
		return hit;
	endfunction

	// output format: invert only the top bit for two's complement
	function automatic logic [DATA_W-1:0] format_code(
		input logic [DATA_W-1:0] raw,
		input logic              tc_n
	);
		logic [DATA_W-1:0] word;
		word = raw;
		if (tc_n == focd_pkg::TC_TWOS) begin
			word[DATA_W-1] = ~raw[DATA_W-1];
		end
		return word;
	endfunction

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	logic                        true_q;
	logic                        comp_q;
	logic [DATA_W-1:0]           raw_code;
	logic                        raw_flag;
	logic [focd_pkg::MODE_W-1:0] clk_mode;
	logic [focd_pkg::EVT_W-1:0]  status;
	logic [focd_pkg::EVT_W-1:0]  mask;

	//------------------------------------------------------------
	// sampling edge and code
	//------------------------------------------------------------
	wire                         rise_true;
	wire                         fall_comp;
	wire                         take;
	wire  [DATA_W-1:0]           next_code;
	wire                         next_flag;

	assign rise_true = i_true_clock & ~true_q;
	assign fall_comp = ~i_complementary_clock & comp_q;
	assign take      = edge_for_mode(clk_mode, rise_true, fall_comp); // [R1] [R2] [R3] [R4]
	assign next_code = i_below_zero ? '0                              // [R5]
	                 : i_above_full ? '1                              // [R6]
	                 : i_conv_code;                                   // [R7]
	assign next_flag = i_below_zero | i_above_full;                   // [R5] [R6] [R7]

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			true_q   <= 1'b1; // a pin already high at release is no edge
			comp_q   <= 1'b0;
			raw_code <= '0;
			raw_flag <= 1'b0;
		end else if (i_ce) begin
			true_q <= i_true_clock;
			comp_q <= i_complementary_clock;
			if (take) begin
				raw_code <= next_code; // [R12]
				raw_flag <= next_flag; // [R12]
			end
		end
	end

	//------------------------------------------------------------
	// output pins
	//------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_sample_word    <= '0;
			o_range_flag     <= 1'b0;
			o_sample_word_oe <= 1'b0;
			o_range_flag_oe  <= 1'b0;
		end else if (i_ce) begin
			o_sample_word    <= format_code(raw_code, i_twos_complement_select_n); // [R8] [R11]
			o_range_flag     <= raw_flag;
			o_sample_word_oe <= ~i_chip_enable_n; // [R9] [R10] [R11]
			o_range_flag_oe  <= ~i_chip_enable_n; // [R10] [R11]
		end
	end

	//------------------------------------------------------------
	// register port
	//------------------------------------------------------------
	wire                         hit_ctrl;
	wire                         hit_status;
	wire                         hit_mask;
	wire                         hit_sample;
	wire  [focd_pkg::EVT_W-1:0]  events;
	wire  [focd_pkg::EVT_W-1:0]  next_status;
	wire  [focd_pkg::BUS_W-1:0]  next_rd_data;
	wire  [focd_pkg::SAMPLE_FLAG-1:0] code_field;

	assign hit_ctrl    = i_addr == focd_pkg::OFF_CTRL;
	assign hit_status  = i_addr == focd_pkg::OFF_STATUS;
	assign hit_mask    = i_addr == focd_pkg::OFF_MASK;
	assign hit_sample  = i_addr == focd_pkg::OFF_SAMPLE;
	assign events      = {take & next_flag & ~i_below_zero, take & i_below_zero, take};
	// read clears, but a same-cycle event survives
	assign next_status = (status & ~{focd_pkg::EVT_W{i_rd & hit_status}}) | events;
	assign code_field  = focd_pkg::SAMPLE_FLAG'(raw_code);
	assign next_rd_data =
		!i_rd       ? '0 :
		hit_ctrl    ? {{(focd_pkg::BUS_W-focd_pkg::MODE_W){1'b0}}, clk_mode} :
		hit_status  ? {{(focd_pkg::BUS_W-focd_pkg::EVT_W){1'b0}}, status} :
		hit_mask    ? {{(focd_pkg::BUS_W-focd_pkg::EVT_W){1'b0}}, mask} :
		hit_sample  ? {{(focd_pkg::BUS_W-focd_pkg::SAMPLE_FLAG-1){1'b0}}, raw_flag, code_field} :
		'0;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			clk_mode  <= focd_pkg::CTRL_RESET;
			mask      <= focd_pkg::MASK_RESET;
			status    <= focd_pkg::STATUS_RESET;
			o_irq     <= 1'b0;
			o_rd_data <= '0;
		end else if (i_ce) begin
			if (i_wr && hit_ctrl) begin
				clk_mode <= i_wr_data[focd_pkg::MODE_W-1:0];
			end
			if (i_wr && hit_mask) begin
				mask <= i_wr_data[focd_pkg::EVT_W-1:0];
			end
			status    <= next_status;
			o_irq     <= |(next_status & mask);
			o_rd_data <= next_rd_data;
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	property p_true_edge;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && clk_mode == focd_pkg::MODE_TTL_TRUE && i_true_clock && !true_q
		 && !i_below_zero && !i_above_full) |=> (raw_code == $past(i_conv_code));
	endproperty
	a_true_edge: assert property (p_true_edge) else $error("true rising edge not sampled"); // [R1]

	property p_comp_edge;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && clk_mode == focd_pkg::MODE_TTL_COMP && !i_complementary_clock && comp_q
		 && !i_below_zero && !i_above_full) |=> (raw_code == $past(i_conv_code));
	endproperty
	a_comp_edge: assert property (p_comp_edge) else $error("comp falling edge not sampled"); // [R2]

	property p_ac_true;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && clk_mode == focd_pkg::MODE_AC_TRUE && !(i_true_clock && !true_q))
		|=> $stable(raw_code) && $stable(raw_flag);
	endproperty
	a_ac_true: assert property (p_ac_true) else $error("sample off the true rising edge"); // [R3]

	property p_ac_comp;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && clk_mode == focd_pkg::MODE_AC_COMP && !(!i_complementary_clock && comp_q))
		|=> $stable(raw_code) && $stable(raw_flag);
	endproperty
	a_ac_comp: assert property (p_ac_comp) else $error("sample off the comp falling edge"); // [R4]

	property p_under;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && take && i_below_zero) |=> raw_flag && raw_code == '0
		##1 (!$past(i_ce) || !$past(i_twos_complement_select_n) || o_sample_word == '0);
	endproperty
	a_under: assert property (p_under) else $error("underflow code wrong"); // [R5]

	property p_over;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && take && i_above_full && !i_below_zero) |=> raw_flag && raw_code == '1;
	endproperty
	a_over: assert property (p_over) else $error("overflow code wrong"); // [R6]

	property p_in_range;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && take && !next_flag) |=> !raw_flag ##1 (!$past(i_ce) || !o_range_flag);
	endproperty
	a_in_range: assert property (p_in_range) else $error("range flag set in range"); // [R7]

	property p_twos;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && i_twos_complement_select_n == focd_pkg::TC_TWOS) |=>
		o_sample_word == {~$past(raw_code[DATA_W-1]), $past(raw_code[DATA_W-2:0])};
	endproperty
	a_twos: assert property (p_twos) else $error("two's complement word wrong"); // [R8]

	property p_float;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && i_chip_enable_n) |=> !o_sample_word_oe && !o_range_flag_oe;
	endproperty
	a_float: assert property (p_float) else $error("outputs driven while disabled"); // [R10]

	property p_drive;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && !i_chip_enable_n) |=> o_sample_word_oe && o_range_flag_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("outputs floated while enabled"); // [R11]

	property p_together;
		@(posedge i_core_clk) disable iff (i_rst)
		($changed(raw_code) || $changed(raw_flag)) |-> $past(take) && $past(i_ce);
	endproperty
	a_together: assert property (p_together) else $error("sample changed without an edge"); // [R12]

	property p_binary;
		@(posedge i_core_clk) disable iff (i_rst)
		(i_ce && i_twos_complement_select_n != focd_pkg::TC_TWOS) |=> o_sample_word == $past(raw_code);
	endproperty
	a_binary: assert property (p_binary) else $error("binary word wrong"); // [R7]

	property p_flag_out;
		@(posedge i_core_clk) disable iff (i_rst)
		i_ce |=> o_range_flag == $past(raw_flag);
	endproperty
	a_flag_out: assert property (p_flag_out) else $error("flag out of step with word"); // [R12]

endmodule

// [dv/focd_capture.sv]
// downstream capture model: resolves the three-state sample lines it sees
// assumes the coder's data and flag outputs with their enables, one core clock
`timescale 1ns/1ns

//------------------------------------------------------------
// capture model
//------------------------------------------------------------
module focd_capture (
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_sample_word,
	input  wire logic       i_sample_word_oe,
	input  wire logic       i_range_flag,
	input  wire logic       i_range_flag_oe,
	output logic      [7:0] o_bus_word,
	output logic            o_bus_flag
);
	logic [7:0] last_word = 8'h00;
	logic       last_flag = 1'h0;

	// floated lines show the inverse of the last driven value
	assign o_bus_word = i_sample_word_oe ? i_sample_word : ~last_word;
	assign o_bus_flag = i_range_flag_oe ? i_range_flag : ~last_flag;

	always_ff @(posedge i_core_clk) begin
		if (i_sample_word_oe) last_word <= i_sample_word;
		if (i_range_flag_oe) last_flag <= i_range_flag;
	end
endmodule

// [dv/tb_flash_adc_output_coder.sv]
// testbench for the output coder: sampling modes, coding, range flag, floating, irq
// assumes the coder in rtl/ and the capture model in dv/
`timescale 1ns/1ns

//------------------------------------------------------------
// bench
//------------------------------------------------------------
module tb_flash_adc_output_coder;
	logic clk = 0, rst = 1, ce = 1, tclk = 0, cclk = 1, below = 0, above = 0;
	logic cen_n = 1, tc_n = 1, wr = 0, rd = 0;
	logic [7:0]  code = 8'h00, addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rd_data;
	logic [7:0]  sw, bus_word;
	logic        sw_oe, rf, rf_oe, irq, bus_flag, smp_chk = 0;
	logic        rd_pipe = 1'b0;
	logic [31:0] exp_rd[$];
	logic [8:0]  exp_smp[$];
	int          fail_count = 0, tests_run = 0, seed = 61;

	always #2 clk = ~clk;

	focd_coder u_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_true_clock(tclk),
		.i_complementary_clock(cclk), .i_conv_code(code), .i_below_zero(below),
		.i_above_full(above), .i_chip_enable_n(cen_n), .i_twos_complement_select_n(tc_n),
		.i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data),
		.o_sample_word(sw), .o_sample_word_oe(sw_oe), .o_range_flag(rf),
		.o_range_flag_oe(rf_oe), .o_irq(irq));
	focd_capture u_cap (.i_core_clk(clk), .i_sample_word(sw), .i_sample_word_oe(sw_oe),
		.i_range_flag(rf), .i_range_flag_oe(rf_oe), .o_bus_word(bus_word),
		.o_bus_flag(bus_flag));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk) wr <= 0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 0;
	endtask

	// decoy edge on the unselected pin, then the real edge on the selected one
	task automatic sample(input logic [1:0] m, input logic [7:0] c, input logic b, a);
		logic [7:0] w;
		w = b ? 8'h00 : (a ? 8'hFF : c);
		if (!tc_n) w[7] = ~w[7];
		exp_smp.push_back({b | a, w});
		@(posedge clk) code <= ~c;
		if (m[0]) tclk <= 1; else cclk <= 0;
		@(posedge clk) {tclk, cclk} <= 2'b01;
		@(posedge clk) {code, below, above} <= {c, b, a};
		if (m[0]) cclk <= 0; else tclk <= 1;
		@(posedge clk) {tclk, cclk} <= 2'b01;
		repeat (3) @(posedge clk);
		smp_chk <= 1;
		@(posedge clk) smp_chk <= 0;
	endtask

	always @(posedge clk) rd_pipe <= rd;

	always @(negedge clk) begin
		if (rd_pipe) chk(rd_data, exp_rd.pop_front());
		if (smp_chk) chk({23'h0, bus_flag, bus_word}, {23'h0, exp_smp.pop_front()});
	end

	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		$display("watchdog expired");
		results();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		rd_reg(focd_pkg::OFF_CTRL, 0);
		rd_reg(focd_pkg::OFF_MASK, 0);
		rd_reg(8'h10, 0);
		wr_reg(8'h10, 32'hFFFFFFFF);
		rd_reg(8'h10, 0);
		$display("test register reset done");
		cen_n <= 0;
		for (int m = 0; m < 4; m++) begin
			wr_reg(focd_pkg::OFF_CTRL, 32'(m));
			rd_reg(focd_pkg::OFF_CTRL, 32'(m));
			for (int t = 0; t < 2; t++) begin
				@(posedge clk) tc_n <= t[0];
				@(posedge clk);
				sample(2'(m), 8'h00, 0, 0);
				sample(2'(m), 8'hFF, 0, 0);
				sample(2'(m), 8'($random(seed)), 0, 0);
				sample(2'(m), 8'($random(seed)), 1, 0);
				sample(2'(m), 8'($random(seed)), 0, 1);
				sample(2'(m), 8'($random(seed)), 1, 1);
			end
			$display("test mode %0d done", m);
		end
		rd_reg(focd_pkg::OFF_STATUS, 32'h7);
		rd_reg(focd_pkg::OFF_STATUS, 32'h0);
		wr_reg(focd_pkg::OFF_CTRL, 0);
		@(negedge clk) chk(32'(irq), 0);
		wr_reg(focd_pkg::OFF_MASK, 32'h1);
		sample(2'h0, 8'h12, 0, 0);
		@(negedge clk) chk(32'(irq), 1);
		rd_reg(focd_pkg::OFF_STATUS, 32'h1);
		repeat (3) @(posedge clk);
		@(negedge clk) chk(32'(irq), 0);
		wr_reg(focd_pkg::OFF_MASK, 32'h6);
		sample(2'h0, 8'h34, 0, 0);
		@(negedge clk) chk(32'(irq), 0);
		sample(2'h0, 8'h56, 0, 1);
		@(negedge clk) chk(32'(irq), 1);
		rd_reg(focd_pkg::OFF_MASK, 32'h6);
		rd_reg(focd_pkg::OFF_STATUS, 32'h5);
		rd_reg(focd_pkg::OFF_SAMPLE, 32'h1FF);
		$display("test interrupt done");
		// edge and in-range code while frozen must leave the word alone
		@(posedge clk) {ce, code, above, tclk} <= {1'b0, 8'h78, 1'b0, 1'b1};
		@(posedge clk) tclk <= 1'b0;
		@(posedge clk) ce <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) chk({23'h0, bus_flag, bus_word}, 32'h1FF);
		$display("test clock enable done");
		@(posedge clk) cen_n <= 1;
		repeat (3) @(posedge clk);
		@(negedge clk) chk({30'h0, sw_oe, rf_oe}, 0);
		@(posedge clk) tc_n <= 0;
		repeat (3) @(posedge clk);
		@(negedge clk) chk({30'h0, sw_oe, rf_oe}, 0);
		@(posedge clk) cen_n <= 0;
		repeat (3) @(posedge clk);
		@(negedge clk) chk({30'h0, sw_oe, rf_oe}, 3);
		$display("test chip enable done");
		results();
	end
endmodule
